// [fcel_map.svh]
// Offsets, field positions and reset values of the flow channel event logic.
// Assumes APB byte addressing, 32-bit data, registers in the low bits.
// Operation
// - One interrupt request fed by the two channel flow done flags.
// - Each flow done flag is gated by its own channel enable bit.
// - A global interrupt enable further gates the controller interrupt request.
// - Interrupt asserted whenever either enabled flow done flag is set.
// - Hardware sets a channel flag when its programmed flow completes.
// - Immediate abort sets the flag once the current byte has finished.
// - Delayed abort sets the flag once the current data packet has finished.
// - Abort during descriptor writing never sets the channel flag.
// - Writing one to the acknowledge bit clears that channel flag.
// - Software can never set a flow done flag directly.
// - Abort mode clear stops after the byte, set after the packet.
// - Busy sets when the descriptor is complete, clears on end or abort.
// - Abort during descriptor writing resets that channel descriptor contents.
// - After abort, two descriptor reads return remaining packets, MSB first.
`ifndef FCEL_MAP_SVH
`define FCEL_MAP_SVH

// ==========================================================
// Register byte offsets
`define FCEL_OFF_CFG      8'h00
`define FCEL_OFF_CHCTRL   8'h04
`define FCEL_OFF_STATUS   8'h08
`define FCEL_OFF_CPUIEN   8'h0c
`define FCEL_OFF_DESC0    8'h10
`define FCEL_OFF_DESC1    8'h14

// ==========================================================
// Field positions
`define FCEL_CFG_EN_BIT   0
`define FCEL_CFG_MODE_BIT 1
`define FCEL_CFG_PRIO_LSB 2
`define FCEL_CH_STRIDE    4
`define FCEL_CC_ABT_BIT   0
`define FCEL_CC_ACK_BIT   1
`define FCEL_CC_EN_BIT    2
`define FCEL_ST_BUSY_BIT  0
`define FCEL_ST_FLAG_BIT  1
`define FCEL_IEN_GLB_BIT  0

// ==========================================================
// Descriptor layout and reset values
`define FCEL_DESC_CNT_HI  3'h3
`define FCEL_DESC_LAST    3'h4
`define FCEL_DESC_AW      3
`define FCEL_CNT_ONE      16'h0001
`define FCEL_CNT_ZERO     16'h0000
`define FCEL_RST_BYTE     8'h00
`define FCEL_RST_WORD     32'h0000_0000

`endif

// [fcel_pkg.sv]
// Types shared by the flow channel event logic.
// Assumes fcel_map.svh supplies all numeric constants.
package fcel_pkg;

  // Channel sequencing states
  typedef enum logic [1:0] {FCEL_IDLE, FCEL_RUN, FCEL_ABT_BYTE, FCEL_ABT_PKT} fcel_state_t;

  // Progress strobes from the data path of one channel
  typedef struct packed {
    logic byte_done;
    logic pkt_done;
  } fcel_dp_t;

  // Channel state seen by software
  typedef struct packed {
    logic        busy;
    logic        flag;
    logic [15:0] remain;
  } fcel_stat_t;

endpackage

// [fcel_desc_mem.sv]
// Descriptor byte store for both channels, registered read port.
// Assumes the top address bit selects the channel.
`timescale 1ns/1ps
`include "fcel_map.svh"
module fcel_desc_mem import fcel_pkg::*; #(
  parameter int DW    = 8,
  parameter int AW    = 4,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [1:0]    clr_ch,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_reg  [DEPTH];
  logic [DW-1:0] mem_next [DEPTH];
  logic [DW-1:0] rd_next;

  // ==========================================================
  // Entries: a channel clear wipes its half, beating any write
  for (genvar e = 0; e < DEPTH; e++)
  begin : g_ent
    always_comb
    begin
      mem_next[e] = mem_reg[e];
      if (clr_ch[e / (DEPTH / 2)])
        mem_next[e] = '0;
      else if (wr_en && wr_addr == AW'(e))
        mem_next[e] = wr_data;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        mem_reg[e] <= '0;
      else
        mem_reg[e] <= mem_next[e];
    end
  end

  // ==========================================================
  // Registered read
  always_comb
  begin
    rd_next = mem_reg[rd_addr];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rd_data <= '0;
    else
      rd_data <= rd_next;
  end

endmodule

// [fcel_channel.sv]
// One channel: descriptor loading, busy, aborts and the flow done flag.
// Assumes progress strobes arrive on the same clock, one cycle wide.
`timescale 1ns/1ps
`include "fcel_map.svh"
module fcel_channel import fcel_pkg::*; #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Software strobes
  input  wire logic             desc_wr,
  input  wire logic [7:0]       desc_byte,
  input  wire logic             abort_req,
  input  wire logic             abort_mode_sel,
  input  wire logic             ack,
  input  wire logic             enable,
  // Data path
  input  wire fcel_dp_t         dp,
  output logic                  run,
  // State out
  output fcel_stat_t            stat,
  output logic [`FCEL_DESC_AW-1:0] wr_idx,
  output logic                  desc_clr
);

  fcel_state_t      state_reg, state_next;
  logic [7:0]       hi_reg, hi_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [`FCEL_DESC_AW-1:0] idx_next;
  logic             flag_next, busy_next, run_next, clr_next, set_ev;

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    hi_next    = hi_reg;
    cnt_next   = cnt_reg;
    idx_next   = wr_idx;
    clr_next   = 1'b0;
    set_ev     = 1'b0;
    // Packet countdown; zero means continuous, never ends
    if (state_reg != FCEL_IDLE && dp.pkt_done && cnt_reg != `FCEL_CNT_ZERO)
      cnt_next = cnt_reg - `FCEL_CNT_ONE;
    case (state_reg)
      FCEL_IDLE:
      begin
        if (abort_req && wr_idx != '0)
        begin
          idx_next = '0;    // Half-written descriptor dropped, no flag
          clr_next = 1'b1;
          cnt_next = '0;
        end
        else if (desc_wr)
        begin
          if (wr_idx == `FCEL_DESC_CNT_HI)
            hi_next = desc_byte;
          if (wr_idx == `FCEL_DESC_LAST)
          begin
            cnt_next   = {hi_reg, desc_byte};
            idx_next   = '0;
            state_next = FCEL_RUN;
          end
          else
            idx_next = wr_idx + 1'b1;
        end
      end
      FCEL_RUN:
      begin
        if (dp.pkt_done && cnt_reg == `FCEL_CNT_ONE)
        begin
          set_ev     = 1'b1;
          state_next = FCEL_IDLE;
        end
        else if (abort_req)
          state_next = abort_mode_sel ? FCEL_ABT_PKT : FCEL_ABT_BYTE;
      end
      FCEL_ABT_BYTE:
      begin
        if (dp.byte_done || dp.pkt_done)
        begin
          set_ev     = 1'b1;
          state_next = FCEL_IDLE;
        end
      end
      FCEL_ABT_PKT:
      begin
        if (dp.pkt_done)
        begin
          set_ev     = 1'b1;
          state_next = FCEL_IDLE;
        end
      end
      default:
        state_next = FCEL_IDLE;
    endcase
    // Set beats a same-cycle acknowledge
    flag_next = set_ev | (stat.flag & ~ack);
    busy_next = (state_next != FCEL_IDLE);
    run_next  = busy_next & enable;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= FCEL_IDLE;
      hi_reg    <= `FCEL_RST_BYTE;
      cnt_reg   <= '0;
      wr_idx    <= '0;
      desc_clr  <= 1'b0;
      stat      <= '0;
      run       <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      hi_reg      <= hi_next;
      cnt_reg     <= cnt_next;
      wr_idx      <= idx_next;
      desc_clr    <= clr_next;
      stat.busy   <= busy_next;
      stat.flag   <= flag_next;
      stat.remain <= CNT_W'(cnt_next);
      run         <= run_next;
    end
  end

endmodule

// [fcel_top.sv]
// Flow channel event logic: APB registers, two channels, interrupt request.
// Assumes the data path moves bytes and reports byte and packet ends.
// Software ends the bus request; the slave adds one wait cycle.
`timescale 1ns/1ps
`include "fcel_map.svh"
module fcel_top import fcel_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int NCH    = 2
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // Data path
  input  wire fcel_dp_t [NCH-1:0] dp_evt,
  input  wire logic [3:0]        dp_rd_addr,
  output logic      [NCH-1:0]    ch_run,
  output logic      [1:0]        ch_prio,
  output logic      [7:0]        dp_rd_data,
  // Interrupt
  output logic                   irq
);

  // ==========================================================
  // Declarations
  logic             en_reg, en_next;
  logic             mode_reg, mode_next;
  logic [1:0]       prio_next;
  logic [NCH-1:0]   ien_reg, ien_next;
  logic             gie_reg, gie_next;
  logic [NCH-1:0]   msb_sel_reg, msb_sel_next;
  logic             pready_next, pslverr_next, irq_next;
  logic [31:0]      prdata_next;
  logic             acc, wr_fire, rd_fire;
  logic             hit_cfg, hit_cc, hit_st, hit_ien, mapped;
  logic [NCH-1:0]   hit_desc;
  logic [NCH-1:0]   abort_p, ack_p, dwr_p, clr_ch, run_w;
  fcel_stat_t [NCH-1:0] stat;
  logic [`FCEL_DESC_AW-1:0] idx [NCH];
  logic             mem_wr;
  logic [3:0]       mem_addr;
  logic [31:0]      st_word, cc_word;

  // ==========================================================
  // Bus phases: write and read take effect at the pready edge
  assign acc     = psel & penable;
  assign wr_fire = acc & pready & pwrite;
  assign rd_fire = acc & pready & ~pwrite;

  // Address decode
  assign hit_cfg     = (paddr == `FCEL_OFF_CFG);
  assign hit_cc      = (paddr == `FCEL_OFF_CHCTRL);
  assign hit_st      = (paddr == `FCEL_OFF_STATUS);
  assign hit_ien     = (paddr == `FCEL_OFF_CPUIEN);
  assign hit_desc[0] = (paddr == `FCEL_OFF_DESC0);
  assign hit_desc[1] = (paddr == `FCEL_OFF_DESC1);
  assign mapped      = hit_cfg | hit_cc | hit_st | hit_ien | (|hit_desc);

  // ==========================================================
  // Per-channel strobes and the status and control words
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    // Acknowledge via control bit, or write-one to the status flag
    assign ack_p[c] = wr_fire & ((hit_cc & pwdata[c*`FCEL_CH_STRIDE + `FCEL_CC_ACK_BIT])
                    | (hit_st & pwdata[c*`FCEL_CH_STRIDE + `FCEL_ST_FLAG_BIT]));
    assign abort_p[c] = wr_fire & hit_cc & pwdata[c*`FCEL_CH_STRIDE + `FCEL_CC_ABT_BIT];
    assign dwr_p[c]   = wr_fire & hit_desc[c] & ~stat[c].busy;
    assign st_word[c*`FCEL_CH_STRIDE + `FCEL_ST_BUSY_BIT] = stat[c].busy;
    assign st_word[c*`FCEL_CH_STRIDE + `FCEL_ST_FLAG_BIT] = stat[c].flag;
    assign st_word[c*`FCEL_CH_STRIDE + 3 -: 2]            = 2'h0;
    assign cc_word[c*`FCEL_CH_STRIDE + `FCEL_CC_EN_BIT]   = ien_reg[c];
    assign cc_word[c*`FCEL_CH_STRIDE + 1 -: 2]            = 2'h0; // Strobes read zero
    assign cc_word[c*`FCEL_CH_STRIDE + 3]                 = 1'b0;

    fcel_channel #(
      .CNT_W (16)
    ) u_ch (
      .clk            (pclk),
      .rstn           (presetn),
      .desc_wr        (dwr_p[c]),
      .desc_byte      (pwdata[7:0]),
      .abort_req      (abort_p[c]),
      .abort_mode_sel (mode_reg),
      .ack            (ack_p[c]),
      .enable         (en_reg),
      .dp             (dp_evt[c]),
      .run            (run_w[c]),
      .stat           (stat[c]),
      .wr_idx         (idx[c]),
      .desc_clr       (clr_ch[c])
    );
  end
  assign st_word[31:NCH*`FCEL_CH_STRIDE] = '0;
  assign cc_word[31:NCH*`FCEL_CH_STRIDE] = '0;
  assign ch_run = run_w;

  // ==========================================================
  // Descriptor store; a busy channel ignores descriptor bytes
  assign mem_wr   = |dwr_p;
  assign mem_addr = dwr_p[1] ? {1'b1, idx[1]} : {1'b0, idx[0]};

  fcel_desc_mem #(
    .DW    (8),
    .AW    (4),
    .DEPTH (16)
  ) u_mem (
    .clk     (pclk),
    .rstn    (presetn),
    .wr_en   (mem_wr),
    .wr_addr (mem_addr),
    .wr_data (pwdata[7:0]),
    .clr_ch  (clr_ch),
    .rd_addr (dp_rd_addr),
    .rd_data (dp_rd_data)
  );

  // ==========================================================
  // Configuration, enables and remaining-count byte select
  always_comb
  begin
    en_next      = en_reg;
    mode_next    = mode_reg;
    prio_next    = ch_prio;
    ien_next     = ien_reg;
    gie_next     = gie_reg;
    msb_sel_next = msb_sel_reg;
    if (wr_fire && hit_cfg)
    begin
      en_next   = pwdata[`FCEL_CFG_EN_BIT];
      mode_next = pwdata[`FCEL_CFG_MODE_BIT];
      prio_next = pwdata[`FCEL_CFG_PRIO_LSB +: 2];
    end
    else if (wr_fire && hit_cc)
    begin
      ien_next[0] = pwdata[`FCEL_CC_EN_BIT];
      ien_next[1] = pwdata[`FCEL_CH_STRIDE + `FCEL_CC_EN_BIT];
    end
    else if (wr_fire && hit_ien)
      gie_next = pwdata[`FCEL_IEN_GLB_BIT];
    // Each descriptor read flips MSB/LSB; abort or new write restarts at MSB
    for (int c = 0; c < NCH; c++)
    begin
      if (abort_p[c] || dwr_p[c])
        msb_sel_next[c] = 1'b0;
      else if (rd_fire && hit_desc[c])
        msb_sel_next[c] = ~msb_sel_reg[c];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_reg      <= 1'b0;
      mode_reg    <= 1'b0;
      ch_prio     <= 2'h0;
      ien_reg     <= '0;
      gie_reg     <= 1'b0;
      msb_sel_reg <= '0;
    end
    else
    begin
      en_reg      <= en_next;
      mode_reg    <= mode_next;
      ch_prio     <= prio_next;
      ien_reg     <= ien_next;
      gie_reg     <= gie_next;
      msb_sel_reg <= msb_sel_next;
    end
  end

  // ==========================================================
  // APB answer: one wait cycle keeps every bus output registered
  always_comb
  begin
    pready_next  = acc & ~pready;
    pslverr_next = 1'b0;
    prdata_next  = `FCEL_RST_WORD;
    if (acc && !pready)
    begin
      pslverr_next = ~mapped;
      if (pwrite)
        prdata_next = `FCEL_RST_WORD;
      else if (hit_cfg)
        prdata_next = {28'h0, ch_prio, mode_reg, en_reg};
      else if (hit_cc)
        prdata_next = cc_word;
      else if (hit_st)
        prdata_next = st_word;
      else if (hit_ien)
        prdata_next = {31'h0, gie_reg};
      else if (hit_desc[0])
        prdata_next = {24'h0, msb_sel_reg[0] ? stat[0].remain[7:0] : stat[0].remain[15:8]};
      else if (hit_desc[1])
        prdata_next = {24'h0, msb_sel_reg[1] ? stat[1].remain[7:0] : stat[1].remain[15:8]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `FCEL_RST_WORD;
    end
    else
    begin
      pready  <= pready_next;
      pslverr <= pslverr_next;
      prdata  <= prdata_next;
    end
  end

  // ==========================================================
  // Interrupt: one level request from two gated sources
  always_comb
  begin
    irq_next = gie_reg & |(ien_reg & {stat[1].flag, stat[0].flag});
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= irq_next;
  end

endmodule

// [fcel_chk_sva.sv]
// Port checker for the flow channel event logic top.
// Assumes one pclk domain and presetn active low.
`timescale 1ns/1ps
module fcel_chk import fcel_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int NCH    = 2
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Data path and interrupt
  input wire fcel_dp_t [NCH-1:0] dp_evt,
  input wire logic [NCH-1:0]    ch_run,
  input wire logic [1:0]        ch_prio,
  input wire logic              irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [NCH-1:0] strb;
  logic           wr_done;
  // ==========================================
  // Helper terms
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      strb[i] = dp_evt[i].byte_done | dp_evt[i].pkt_done;
  end
  assign wr_done = pready && pwrite;
  sequence s_acc_start;
    psel && penable && !$past(penable);
  endsequence
  sequence s_irq_low;
    ##2 (!irq) [*2];
  endsequence
  // ==========================================
  // Assertions
  chk_wait_state: assert property (s_acc_start |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  chk_err_read: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error response malformed");
  chk_reset_quiet: assert property ($rose(presetn) |-> !irq && ch_run == '0)
    else $error("outputs active after reset");
  chk_global_gate: assert property (wr_done && paddr == 8'h0c && !pwdata[0] |-> s_irq_low)
    else $error("irq without global enable");
  chk_chan_gate: assert property (wr_done && paddr == 8'h04 && !pwdata[2] && !pwdata[6] |-> s_irq_low)
    else $error("irq without channel enable");
  chk_irq_cause: assert property ($rose(irq) |-> $past(|strb, 2) || $past(wr_done) || $past(wr_done, 2))
    else $error("irq rose without cause");
  chk_run_end: assert property ($fell(ch_run[0]) |-> $past(strb[0]) || $past(wr_done, 2))
    else $error("run fell without cause");
  chk_prio_write: assert property (!$stable(ch_prio) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("priority changed without write");
endmodule

bind fcel_top fcel_chk #(.ADDR_W(ADDR_W), .NCH(NCH)) chk_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .dp_evt(dp_evt), .ch_run(ch_run), .ch_prio(ch_prio), .irq(irq));

// [fcel_dp_model.sv]
// Data path model: byte and packet end strobes for each channel.
// Assumes strobes count only while the channel runs.
`timescale 1ns/1ps
module fcel_dp_model import fcel_pkg::*; #(
  parameter int NCH = 2
) (
  // Clock
  input  wire logic           pclk,
  // Channel run levels
  input  wire logic [NCH-1:0] ch_run,
  // Progress strobes
  output fcel_dp_t  [NCH-1:0] dp_evt
);
  initial dp_evt = '0;
  // One byte end, with a packet end if asked; a stopped channel moves nothing
  task automatic pulse(input int ch, input logic pkt);
    @(posedge pclk);
    if (ch_run[ch])
    begin
      dp_evt[ch] <= {1'b1, pkt};
      @(posedge pclk);
    end
    dp_evt <= '0;
  endtask
endmodule

// [fcel_tb.sv]
// Self-checking bench for the flow channel event logic.
// Assumes APB master tasks and the data path model drive all inputs.
`timescale 1ns/1ps
module testbench;
  import fcel_pkg::*;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [31:0]     pwdata = 32'h0;
  logic            pready;
  logic [31:0]     prdata;
  logic            pslverr;
  fcel_dp_t [1:0]  dp_evt;
  logic [3:0]      dp_rd_addr = 4'h0;
  logic [1:0]      ch_run;
  logic [1:0]      ch_prio;
  logic [7:0]      dp_rd_data;
  logic            irq;
  logic [31:0]     rdat;
  logic            rerr;
  int              num_errors = 0;
  int              cmp_count = 0;
  int              cycles = 0;

  fcel_top fcel_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .dp_evt(dp_evt),
    .dp_rd_addr(dp_rd_addr), .ch_run(ch_run), .ch_prio(ch_prio), .dp_rd_data(dp_rd_data), .irq(irq));
  fcel_dp_model fcel_dp_model_i (.pclk(pclk), .ch_run(ch_run), .dp_evt(dp_evt));

  // ==========================================
  // Clock and hang guard
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      conclude();
    end
  end

  // ==========================================
  // Tasks
  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until ready is sampled high; no fixed latency assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // Descriptor bytes go out first byte first
  task automatic wdesc(input logic [7:0] a, input logic [39:0] v, input int n);
    for (int i = 0; i < n; i++)
      wr(a, {24'h0, v[39-8*i -: 8]});
  endtask
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h4);
    wr(8'h00, 32'h5);
    @(posedge pclk);
    chk({30'h0, ch_prio}, 32'h1);
    rd(8'h00, 32'h5);
    wdesc(8'h10, 40'h01_02_00_00_01, 5);
    rd(8'h08, 32'h01);
    chk({30'h0, ch_run}, 32'h1);
    // Controller enable gates the run level of a busy channel
    wr(8'h00, 32'h4);
    repeat (2) @(posedge pclk);
    chk({30'h0, ch_run}, 32'h0);
    wr(8'h00, 32'h5);
    rd(8'h08, 32'h01);
    fcel_dp_model_i.pulse(0, 1'b1);
    rd(8'h08, 32'h02);
    wr(8'h0c, 32'h1);
    irq_is(1'b0);
    wr(8'h04, 32'h04);
    irq_is(1'b1);
    wr(8'h0c, 32'h0);
    irq_is(1'b0);
    wr(8'h0c, 32'h1);
    irq_is(1'b1);
    wr(8'h04, 32'h00);
    irq_is(1'b0);
    wr(8'h04, 32'h04);
    irq_is(1'b1);
    wr(8'h08, 32'h20);
    rd(8'h08, 32'h02);
    wr(8'h04, 32'h06);
    rd(8'h08, 32'h0);
    irq_is(1'b0);
    // Immediate abort ends at the next byte
    wr(8'h04, 32'h44);
    wdesc(8'h14, 40'h01_02_00_00_05, 5);
    wr(8'h04, 32'h54);
    rd(8'h08, 32'h10);
    fcel_dp_model_i.pulse(1, 1'b0);
    rd(8'h08, 32'h20);
    irq_is(1'b1);
    rd(8'h14, 32'h0);
    rd(8'h14, 32'h5);
    wr(8'h04, 32'h64);
    // Delayed abort waits for the packet end
    wr(8'h00, 32'h7);
    wdesc(8'h10, 40'h01_02_00_00_03, 5);
    fcel_dp_model_i.pulse(0, 1'b1);
    wr(8'h04, 32'h45);
    fcel_dp_model_i.pulse(0, 1'b0);
    rd(8'h08, 32'h01);
    fcel_dp_model_i.pulse(0, 1'b1);
    rd(8'h08, 32'h02);
    rd(8'h10, 32'h0);
    rd(8'h10, 32'h1);
    wr(8'h04, 32'h46);
    // Abort on a half written descriptor
    wdesc(8'h14, 40'h11_22_00_00_00, 2);
    wr(8'h04, 32'h54);
    rd(8'h08, 32'h0);
    dp_rd_addr <= 4'h8;
    repeat (2) @(posedge pclk);
    chk({24'h0, dp_rd_data}, 32'h0);
    wdesc(8'h14, 40'h01_02_00_00_01, 3);
    rd(8'h08, 32'h0);
    wdesc(8'h14, 40'h00_01_00_00_00, 2);
    rd(8'h08, 32'h10);
    fcel_dp_model_i.pulse(1, 1'b1);
    rd(8'h08, 32'h20);
    wr(8'h08, 32'h20);
    rd(8'h08, 32'h0);
    // Unmapped place answers with an error and no data
    rd(8'h20, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    conclude();
  end
endmodule
